// ===== core/sch_pkg.sv
package sch_pkg;

  // ----------------------------------------------------------------
  // bus command and field layout
  // ----------------------------------------------------------------
  localparam logic [3:0]  SCH_CMD_SPLIT_COMPLETION = 4'hC;
  localparam int          SCH_AD_RLX_BIT           = 30;
  localparam int          SCH_AD_TAG_LSB           = 24;
  localparam int          SCH_AD_RBUS_LSB          = 16;
  localparam int          SCH_AD_RDEV_LSB          = 11;
  localparam int          SCH_AD_RFN_LSB           = 8;
  localparam int          SCH_AD_LADDR_LSB         = 0;
  localparam int          SCH_AT_BC_MOD_BIT        = 31;
  localparam int          SCH_AT_ERR_BIT           = 30;
  localparam int          SCH_AT_MSG_BIT           = 29;
  localparam int          SCH_AT_CBUS_LSB          = 16;
  localparam int          SCH_AT_CDEV_LSB          = 11;
  localparam int          SCH_AT_CFN_LSB           = 8;
  localparam int          SCH_AT_LBC_LSB           = 0;
  localparam logic [31:0] SCH_ADDR_RSVD_MASK       = 32'hA000_0080;
  localparam logic [31:0] SCH_ATTR_RSVD_MASK       = 32'h1F00_0000;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [12:0] SCH_MSG_BYTES        = 13'h0004;
  localparam logic [12:0] SCH_ZERO_BYTES       = 13'h0000;
  localparam logic [6:0]  SCH_LADDR_ZERO       = 7'h00;
  localparam logic [7:0]  SCH_BUS_UNINIT       = 8'hFF;
  localparam logic [4:0]  SCH_DEV_UNINIT       = 5'h1F;
  localparam logic [4:0]  SCH_SRC_BRIDGE_DEV   = 5'h00;
  localparam logic [3:0]  SCH_CLASS_BRIDGE_ERR = 4'h1;
  localparam logic [3:0]  SCH_CLASS_COMPL_ERR  = 4'h2;
  localparam logic [31:0] SCH_RST_WORD         = 32'h0000_0000;
  localparam logic [3:0]  SCH_RST_CBE          = 4'h0;

  typedef enum logic [1:0] {SCH_IDLE, SCH_ADDR, SCH_ATTR} sch_state_t;

  // ----------------------------------------------------------------
  // byte count coding: code zero stands for 4096 bytes
  // ----------------------------------------------------------------
  function automatic logic [12:0] sch_bc_decode(input logic [11:0] code);
    sch_bc_decode = (code == 12'h000) ? 13'h1000 : {1'b0, code};
  endfunction

  function automatic logic [11:0] sch_bc_encode(input logic [12:0] bytes);
    sch_bc_encode = bytes[11:0];
  endfunction

  function automatic logic sch_is_err_class(input logic [3:0] cls);
    sch_is_err_class = (cls == SCH_CLASS_BRIDGE_ERR) || (cls == SCH_CLASS_COMPL_ERR);
  endfunction

endpackage

// ===== core/sch_fwd_if.sv
interface sch_fwd_if;
  logic       valid;
  logic       on_secondary;
  logic [7:0] req_bus;
  logic [7:0] sec_bus;
  logic [7:0] sub_bus;
  logic       primary_pcix;
  logic       up;
  logic       down;

  modport ctl (output valid, output on_secondary, output req_bus, output sec_bus,
               output sub_bus, output primary_pcix, input up, input down);
  modport dec (input valid, input on_secondary, input req_bus, input sec_bus,
               input sub_bus, input primary_pcix, output up, output down);
endinterface

// ===== core/sch_fwd.sv
module sch_fwd
  import sch_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset,
  sch_fwd_if.dec    fwd
);

  // ----------------------------------------------------------------
  // routing decision by requester bus number
  // ----------------------------------------------------------------
  logic in_range;

  assign in_range = (fwd.req_bus >= fwd.sec_bus) && (fwd.req_bus <= fwd.sub_bus);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fwd.up   <= 1'b0;
      fwd.down <= 1'b0;
    end else begin
      fwd.up   <= fwd.valid && fwd.on_secondary && !in_range && fwd.primary_pcix;
      fwd.down <= fwd.valid && !fwd.on_secondary && in_range && !fwd.primary_pcix;
    end
  end

endmodule

// ===== core/sch_top.sv
module sch_top
  import sch_pkg::*;
#(
  parameter logic [2:0] FUNC_NUM = 3'h0
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // request capture
  input  wire logic        seq_start,
  input  wire logic [4:0]  req_tag,
  input  wire logic [7:0]  req_bus,
  input  wire logic [4:0]  req_dev,
  input  wire logic [2:0]  req_fn,
  input  wire logic        req_relaxed_order,
  input  wire logic [6:0]  req_addr_low,
  input  wire logic [11:0] req_byte_count,
  input  wire logic        req_dword,
  input  wire logic        req_burst_block,
  // completion issue
  input  wire logic        cpl_issue,
  input  wire logic        cpl_message,
  input  wire logic [3:0]  cpl_msg_class,
  input  wire logic        cpl_shorten,
  input  wire logic [12:0] cpl_short_count,
  input  wire logic        xfer_done,
  input  wire logic [12:0] xfer_bytes,
  // completer identity
  input  wire logic [7:0]  cap_bus_num,
  input  wire logic [4:0]  cap_dev_num,
  input  wire logic        is_source_bridge,
  // bridge forwarding
  input  wire logic        fwd_in_valid,
  input  wire logic        fwd_in_secondary,
  input  wire logic [31:0] fwd_in_addr,
  input  wire logic [31:0] fwd_in_attr,
  input  wire logic [3:0]  fwd_in_attr_cbe,
  input  wire logic [7:0]  sec_bus_num,
  input  wire logic [7:0]  sub_bus_num,
  input  wire logic        primary_pcix_mode,
  // header outputs
  output logic [31:0]      ad,
  output logic [3:0]       cbe,
  output logic             addr_phase,
  output logic             attr_phase,
  output logic             seq_active,
  output logic             first_pending,
  output logic [12:0]      remaining_bytes,
  output logic             issue_refused,
  output logic             seq_done,
  output logic             bus_num_uninit,
  output logic             dev_num_uninit,
  // forwarding outputs
  output logic             fwd_upstream,
  output logic             fwd_downstream,
  output logic [31:0]      fwd_out_addr,
  output logic [31:0]      fwd_out_attr,
  output logic [3:0]       fwd_out_attr_cbe
);

  // ----------------------------------------------------------------
  // stored request
  // ----------------------------------------------------------------
  logic [4:0]  st_tag;
  logic [7:0]  st_bus;
  logic [4:0]  st_dev;
  logic [2:0]  st_fn;
  logic        st_relaxed;
  logic [6:0]  st_laddr;
  logic        st_dword;
  logic        st_burst_block;

  sch_state_t  state;
  logic        issue_ok;
  logic        msg_pending;
  logic [31:0] next_addr_word;
  logic [31:0] next_attr_word;
  logic [3:0]  next_attr_cbe;
  logic [31:0] hold_attr_word;
  logic [3:0]  hold_attr_cbe;
  logic [12:0] next_count;
  logic [11:0] next_code;
  logic [6:0]  next_laddr;
  logic        next_bc_mod;
  logic        next_err;
  logic        next_msg;
  logic [4:0]  cpl_dev;
  logic        shorten_ok;
  logic        xfer_last;

  assign issue_ok = cpl_issue && seq_active && (state == SCH_IDLE);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_tag         <= 5'h00;
      st_bus         <= 8'h00;
      st_dev         <= 5'h00;
      st_fn          <= 3'h0;
      st_relaxed     <= 1'b0;
      st_laddr       <= 7'h00;
      st_dword       <= 1'b0;
      st_burst_block <= 1'b0;
    end else if (seq_start && !seq_active) begin
      st_tag         <= req_tag;
      st_bus         <= req_bus;
      st_dev         <= req_dev;
      st_fn          <= req_fn;
      st_relaxed     <= req_relaxed_order;
      st_laddr       <= req_addr_low;
      st_dword       <= req_dword;
      st_burst_block <= req_burst_block;
    end
  end

  // ----------------------------------------------------------------
  // sequence tracking
  // ----------------------------------------------------------------
  assign xfer_last = xfer_done && (xfer_bytes >= remaining_bytes);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      seq_active      <= 1'b0;
      first_pending   <= 1'b0;
      remaining_bytes <= SCH_ZERO_BYTES;
      msg_pending     <= 1'b0;
      seq_done        <= 1'b0;
    end else begin
      seq_done <= 1'b0;
      if (seq_start && !seq_active) begin
        seq_active      <= 1'b1;
        first_pending   <= 1'b1;
        remaining_bytes <= sch_bc_decode(req_byte_count);
        msg_pending     <= 1'b0;
      end else if (issue_ok) begin
        first_pending <= 1'b0;
        msg_pending   <= cpl_message;
      end else if (xfer_done && seq_active) begin
        // a message ends the sequence whatever remains
        if (msg_pending || xfer_last) begin
          seq_active      <= 1'b0;
          remaining_bytes <= SCH_ZERO_BYTES;
          seq_done        <= 1'b1;
        end else begin
          remaining_bytes <= remaining_bytes - xfer_bytes;
        end
        msg_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // header field formation
  // ----------------------------------------------------------------
  assign shorten_ok = cpl_shorten && first_pending && st_burst_block && !st_dword &&
                      (cpl_short_count != SCH_ZERO_BYTES) && (cpl_short_count < remaining_bytes);
  assign cpl_dev    = is_source_bridge ? SCH_SRC_BRIDGE_DEV : cap_dev_num;

  always_comb begin
    next_laddr = SCH_LADDR_ZERO;
    next_count = remaining_bytes;
    next_bc_mod = 1'b0;
    next_err    = 1'b0;
    next_msg    = 1'b0;
    if (cpl_message) begin
      next_count = SCH_MSG_BYTES;
      next_msg   = 1'b1;
      next_err   = sch_is_err_class(cpl_msg_class);
    end else if (st_dword) begin
      next_count = SCH_MSG_BYTES;
    end else begin
      if (first_pending) begin
        next_laddr = st_laddr;
      end
      if (shorten_ok) begin
        next_count = cpl_short_count;
        next_bc_mod = 1'b1;
      end
    end
  end

  always_comb begin
    next_code                                         = sch_bc_encode(next_count);
    next_addr_word                                    = SCH_RST_WORD;
    next_addr_word[SCH_AD_RLX_BIT]                    = st_relaxed;
    next_addr_word[SCH_AD_TAG_LSB +: 5]               = st_tag;
    next_addr_word[SCH_AD_RBUS_LSB +: 8]              = st_bus;
    next_addr_word[SCH_AD_RDEV_LSB +: 5]              = st_dev;
    next_addr_word[SCH_AD_RFN_LSB +: 3]               = st_fn;
    next_addr_word[SCH_AD_LADDR_LSB +: 7]             = next_laddr;
    next_attr_word                                    = SCH_RST_WORD;
    next_attr_word[SCH_AT_BC_MOD_BIT]                 = next_bc_mod;
    next_attr_word[SCH_AT_ERR_BIT]                    = next_err;
    next_attr_word[SCH_AT_MSG_BIT]                    = next_msg;
    next_attr_word[SCH_AT_CBUS_LSB +: 8]              = cap_bus_num;
    next_attr_word[SCH_AT_CDEV_LSB +: 5]              = cpl_dev;
    next_attr_word[SCH_AT_CFN_LSB +: 3]               = FUNC_NUM;
    next_attr_word[SCH_AT_LBC_LSB +: 8]               = next_code[7:0];
    next_attr_cbe                                     = next_code[11:8];
  end

  // ----------------------------------------------------------------
  // address then attribute phase
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= SCH_IDLE;
    end else begin
      case (state)
        SCH_IDLE: state <= issue_ok ? SCH_ADDR : SCH_IDLE;
        SCH_ADDR: state <= SCH_ATTR;
        SCH_ATTR: state <= SCH_IDLE;
        default:  state <= SCH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hold_attr_word <= SCH_RST_WORD;
      hold_attr_cbe  <= SCH_RST_CBE;
    end else if (issue_ok) begin
      hold_attr_word <= next_attr_word;
      hold_attr_cbe  <= next_attr_cbe;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ad         <= SCH_RST_WORD;
      cbe        <= SCH_RST_CBE;
      addr_phase <= 1'b0;
      attr_phase <= 1'b0;
    end else begin
      addr_phase <= issue_ok;
      attr_phase <= (state == SCH_ADDR);
      if (issue_ok) begin
        ad  <= next_addr_word;
        cbe <= SCH_CMD_SPLIT_COMPLETION;
      end else if (state == SCH_ADDR) begin
        ad  <= hold_attr_word;
        cbe <= hold_attr_cbe;
      end else begin
        ad  <= SCH_RST_WORD;
        cbe <= SCH_RST_CBE;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      issue_refused <= 1'b0;
    end else begin
      issue_refused <= cpl_issue && !issue_ok;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_num_uninit <= 1'b1;
      dev_num_uninit <= 1'b1;
    end else begin
      bus_num_uninit <= (cap_bus_num == SCH_BUS_UNINIT);
      dev_num_uninit <= !is_source_bridge && (cap_dev_num == SCH_DEV_UNINIT);
    end
  end

  // ----------------------------------------------------------------
  // bridge forwarding
  // ----------------------------------------------------------------
  sch_fwd_if fwd_bus ();

  assign fwd_bus.valid        = fwd_in_valid;
  assign fwd_bus.on_secondary = fwd_in_secondary;
  assign fwd_bus.req_bus      = fwd_in_addr[SCH_AD_RBUS_LSB +: 8];
  assign fwd_bus.sec_bus      = sec_bus_num;
  assign fwd_bus.sub_bus      = sub_bus_num;
  assign fwd_bus.primary_pcix = primary_pcix_mode;

  sch_fwd u_fwd (
    .clk_sys (clk_sys),
    .reset   (reset),
    .fwd     (fwd_bus.dec)
  );

  assign fwd_upstream   = fwd_bus.up;
  assign fwd_downstream = fwd_bus.down;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fwd_out_addr     <= SCH_RST_WORD;
      fwd_out_attr     <= SCH_RST_WORD;
      fwd_out_attr_cbe <= SCH_RST_CBE;
    end else if (fwd_in_valid) begin
      // only reserved address bits change; routing fields pass through
      fwd_out_addr     <= fwd_in_addr & ~SCH_ADDR_RSVD_MASK;
      fwd_out_attr     <= fwd_in_attr;
      fwd_out_attr_cbe <= fwd_in_attr_cbe;
    end
  end

endmodule

// ===== test/sch_chk.sv
module sch_chk
  import sch_pkg::*;
#(
  parameter logic [2:0] FUNC_NUM = 3'h0
) (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        cpl_issue,
  input wire logic        seq_active,
  input wire logic [7:0]  cap_bus_num,
  input wire logic        fwd_in_valid,
  input wire logic        fwd_in_secondary,
  input wire logic [31:0] fwd_in_addr,
  input wire logic [31:0] fwd_in_attr,
  input wire logic [7:0]  sec_bus_num,
  input wire logic [7:0]  sub_bus_num,
  input wire logic        primary_pcix_mode,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe,
  input wire logic        addr_phase,
  input wire logic        attr_phase,
  input wire logic        issue_refused,
  input wire logic        fwd_upstream,
  input wire logic        fwd_downstream,
  input wire logic [31:0] fwd_out_addr,
  input wire logic [31:0] fwd_out_attr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic in_rng;
  assign in_rng = fwd_in_addr[23:16] >= sec_bus_num && fwd_in_addr[23:16] <= sub_bus_num;

  sequence s_hdr; addr_phase ##1 attr_phase; endsequence
  sequence s_msg_attr; attr_phase && ad[SCH_AT_MSG_BIT]; endsequence

  property p_cmd; addr_phase |-> cbe == SCH_CMD_SPLIT_COMPLETION && (ad & SCH_ADDR_RSVD_MASK) == 32'h0; endproperty
  property p_phase; addr_phase |-> s_hdr; endproperty
  property p_rsvd; attr_phase |-> (ad & SCH_ATTR_RSVD_MASK) == 32'h0; endproperty
  property p_flags; attr_phase |-> !(ad[SCH_AT_ERR_BIT] && !ad[SCH_AT_MSG_BIT]); endproperty
  property p_id; attr_phase |-> ad[23:16] == cap_bus_num && ad[10:8] == FUNC_NUM; endproperty
  property p_msg; s_msg_attr |-> $past(ad[6:0]) == 7'h00 && {cbe, ad[7:0]} == 12'h004 && !ad[31]; endproperty
  property p_refuse; cpl_issue && !seq_active |=> issue_refused && !addr_phase; endproperty
  property p_up;
    fwd_in_valid |=> fwd_upstream == $past(fwd_in_secondary && !in_rng && primary_pcix_mode);
  endproperty
  property p_down;
    fwd_in_valid |=> fwd_downstream == $past(!fwd_in_secondary && in_rng && !primary_pcix_mode);
  endproperty
  property p_fwd;
    fwd_in_valid |=> fwd_out_addr == ($past(fwd_in_addr) & ~SCH_ADDR_RSVD_MASK) && fwd_out_attr == $past(fwd_in_attr);
  endproperty

  a_cmd: assert property (p_cmd) else $error("bad address phase command or reserved bits");
  a_phase: assert property (p_phase) else $error("attribute phase missing");
  a_rsvd: assert property (p_rsvd) else $error("attribute reserved bits set");
  a_flags: assert property (p_flags) else $error("error flag without message flag");
  a_id: assert property (p_id) else $error("completer identity wrong");
  a_msg: assert property (p_msg) else $error("message header fields wrong");
  a_refuse: assert property (p_refuse) else $error("issue without sequence not refused");
  a_up: assert property (p_up) else $error("upstream decision wrong");
  a_down: assert property (p_down) else $error("downstream decision wrong");
  a_fwd: assert property (p_fwd) else $error("forwarded words altered");
endmodule

bind sch_top sch_chk #(.FUNC_NUM(FUNC_NUM)) u_chk (.clk_sys, .reset, .cpl_issue, .seq_active, .cap_bus_num,
  .fwd_in_valid, .fwd_in_secondary, .fwd_in_addr, .fwd_in_attr, .sec_bus_num, .sub_bus_num, .primary_pcix_mode,
  .ad, .cbe, .addr_phase, .attr_phase, .issue_refused, .fwd_upstream, .fwd_downstream, .fwd_out_addr, .fwd_out_attr);

// ===== test/sch_req_model.sv
module sch_req_model (
  input  wire logic        clk_sys,
  input  wire logic [31:0] ad,
  input  wire logic [3:0]  cbe,
  input  wire logic        addr_phase,
  input  wire logic        attr_phase,
  input  wire logic [20:0] own_id,
  output logic [31:0]      hdr_addr,
  output logic [35:0]      hdr_attr,
  output logic [12:0]      bytes,
  output logic             match,
  output logic             is_error
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge clk_sys) begin
    if (addr_phase) hdr_addr <= ad;
    if (attr_phase) hdr_attr <= {cbe, ad};
  end

  // reserved bits and the modified flag take no part in decoding
  assign match    = hdr_addr[28:8] == own_id;
  assign is_error = hdr_attr[30] & hdr_attr[29];
  assign bytes    = (hdr_attr[35:32] == 4'h0 && hdr_attr[7:0] == 8'h00) ? 13'h1000
                  : {1'b0, hdr_attr[35:32], hdr_attr[7:0]};
endmodule

// ===== test/sch_top_tb.sv
module sch_top_tb import sch_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] FN = 3'h6;
  localparam logic [7:0] CB = 8'h42;
  localparam logic [4:0] CD = 5'h09;
  logic        clk_sys, reset, seq_start, req_relaxed_order, req_dword, req_burst_block, cpl_issue, cpl_message;
  logic        cpl_shorten, xfer_done, is_source_bridge, fwd_in_valid, fwd_in_secondary, primary_pcix_mode;
  logic        addr_phase, attr_phase, seq_active, first_pending, issue_refused, seq_done, bus_num_uninit;
  logic        dev_num_uninit, fwd_upstream, fwd_downstream, match, is_error;
  logic [2:0]  req_fn;
  logic [3:0]  cpl_msg_class, fwd_in_attr_cbe, cbe, fwd_out_attr_cbe;
  logic [4:0]  req_tag, req_dev, cap_dev_num;
  logic [6:0]  req_addr_low;
  logic [7:0]  req_bus, cap_bus_num, sec_bus_num, sub_bus_num;
  logic [11:0] req_byte_count;
  logic [12:0] cpl_short_count, xfer_bytes, remaining_bytes, bytes;
  logic [31:0] fwd_in_addr, fwd_in_attr, ad, fwd_out_addr, fwd_out_attr, hdr_addr;
  logic [35:0] hdr_attr;
  int          miscompares, tests_run;

  sch_top #(.FUNC_NUM(FN)) u_dut (.clk_sys, .reset, .seq_start, .req_tag, .req_bus, .req_dev, .req_fn,
    .req_relaxed_order, .req_addr_low, .req_byte_count, .req_dword, .req_burst_block, .cpl_issue, .cpl_message,
    .cpl_msg_class, .cpl_shorten, .cpl_short_count, .xfer_done, .xfer_bytes, .cap_bus_num, .cap_dev_num,
    .is_source_bridge, .fwd_in_valid, .fwd_in_secondary, .fwd_in_addr, .fwd_in_attr, .fwd_in_attr_cbe,
    .sec_bus_num, .sub_bus_num, .primary_pcix_mode, .ad, .cbe, .addr_phase, .attr_phase, .seq_active,
    .first_pending, .remaining_bytes, .issue_refused, .seq_done, .bus_num_uninit, .dev_num_uninit,
    .fwd_upstream, .fwd_downstream, .fwd_out_addr, .fwd_out_attr, .fwd_out_attr_cbe);

  sch_req_model u_req (.clk_sys, .ad, .cbe, .addr_phase, .attr_phase, .own_id({req_tag, req_bus, req_dev, req_fn}),
    .hdr_addr, .hdr_attr, .bytes, .match, .is_error);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(string name, logic [35:0] seen, logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic start(logic [4:0] tg, logic [7:0] bs, logic [4:0] dv, logic [2:0] f, logic ro, logic [6:0] la,
                       logic [11:0] bc, logic dw, logic bb);
    {req_tag, req_bus, req_dev, req_fn, req_relaxed_order} = {tg, bs, dv, f, ro};
    {req_addr_low, req_byte_count, req_dword, req_burst_block} = {la, bc, dw, bb};
    seq_start = 1'b1;
    tick;
    seq_start = 1'b0;
  endtask

  // pulse the issue, then wait out the fixed address and attribute phases
  task automatic issue(logic msg, logic [3:0] cls, logic sh, logic [12:0] sc);
    {cpl_message, cpl_msg_class, cpl_shorten, cpl_short_count} = {msg, cls, sh, sc};
    cpl_issue = 1'b1;
    tick;
    cpl_issue = 1'b0;
    tick;
    tick;
  endtask

  task automatic hdr(logic [6:0] la, logic bm, logic ef, logic mf, logic [11:0] bc);
    logic [31:0] ea;
    ea = {1'b0, req_relaxed_order, 1'b0, req_tag, req_bus, req_dev, req_fn, 1'b0, la};
    check("addr", 36'(hdr_addr), 36'(ea));
    check("attr", hdr_attr, {bc[11:8], bm, ef, mf, 5'h00, CB, CD, FN, bc[7:0]});
    check("match", 36'(match), 36'h1);
  endtask

  task automatic done(logic [12:0] n, logic last);
    xfer_bytes = n;
    xfer_done = 1'b1;
    tick;
    xfer_done = 1'b0;
    check("seq_done", 36'(seq_done), 36'(last));
  endtask

  task automatic fwd(logic s, logic [7:0] bs, logic p, logic up, logic dn);
    {fwd_in_secondary, primary_pcix_mode, fwd_in_attr_cbe} = {s, p, 4'hA};
    fwd_in_addr = {8'hFF, bs, 16'hFFFF};
    fwd_in_attr = {8'h1F, bs, 16'h80A5};
    fwd_in_valid = 1'b1;
    tick;
    check("up_down", 36'({fwd_upstream, fwd_downstream}), 36'({up, dn}));
    check("fwd_addr", 36'(fwd_out_addr), 36'(fwd_in_addr & ~SCH_ADDR_RSVD_MASK));
    check("fwd_attr", {fwd_out_attr_cbe, fwd_out_attr}, {4'hA, fwd_in_attr});
  endtask

  initial begin
    {seq_start, req_relaxed_order, req_dword, req_burst_block, cpl_issue, cpl_message, cpl_shorten} = '0;
    {xfer_done, is_source_bridge, fwd_in_valid, fwd_in_secondary, primary_pcix_mode} = '0;
    {req_fn, cpl_msg_class, fwd_in_attr_cbe, req_tag, req_dev, req_addr_low, req_bus, req_byte_count} = '0;
    {cpl_short_count, xfer_bytes, fwd_in_addr, fwd_in_attr} = '0;
    {cap_bus_num, cap_dev_num, sec_bus_num, sub_bus_num} = {8'hFF, 5'h1F, 8'h10, 8'h1F};
    miscompares = 0;
    tests_run = 0;
    reset = 1'b1;
    repeat (5) tick;
    reset = 1'b0;
    tick;
    check("uninit", 36'({bus_num_uninit, dev_num_uninit}), 36'h3);
    is_source_bridge = 1'b1;
    tick;
    tick;
    check("src_bridge", 36'(dev_num_uninit), 36'h0);
    {cap_bus_num, cap_dev_num, is_source_bridge} = {CB, CD, 1'b0};
    cpl_issue = 1'b1;
    tick;
    cpl_issue = 1'b0;
    check("refused", 36'({issue_refused, addr_phase}), 36'h2);
    $display("test reset and refusal done");

    start(5'h15, 8'h3C, 5'h0A, 3'h5, 1'b1, 7'h68, 12'h118, 1'b0, 1'b1);
    check("remaining", 36'(remaining_bytes), 36'h118);
    check("active", 36'({seq_active, first_pending, bus_num_uninit}), 36'h6);
    issue(1'b0, 4'h0, 1'b1, 13'd24);
    hdr(7'h68, 1'b1, 1'b0, 1'b0, 12'd24);
    check("bytes", 36'(bytes), 36'd24);
    done(13'd24, 1'b0);
    check("remaining", 36'(remaining_bytes), 36'd256);
    check("active", 36'({seq_active, first_pending}), 36'h2);
    issue(1'b0, 4'h0, 1'b1, 13'd100);
    hdr(7'h00, 1'b0, 1'b0, 1'b0, 12'h100);
    done(13'd256, 1'b1);
    $display("test shortened burst done");

    for (int c = 0; c < 3; c++) begin
      start(5'h03, 8'h07, 5'h1E, 3'h1, 1'b0, 7'h44, 12'h040, 1'b0, 1'b1);
      issue(1'b1, c[3:0], 1'b1, 13'd8);
      hdr(7'h00, 1'b0, c != 0, 1'b1, 12'h004);
      check("is_error", 36'(is_error), 36'(c != 0));
      done(13'd4, 1'b1);
    end
    $display("test messages done");

    start(5'h1F, 8'hFE, 5'h00, 3'h7, 1'b1, 7'h2C, 12'h004, 1'b1, 1'b0);
    issue(1'b0, 4'h0, 1'b1, 13'd2);
    hdr(7'h00, 1'b0, 1'b0, 1'b0, 12'h004);
    done(13'd4, 1'b1);
    start(5'h00, 8'h00, 5'h00, 3'h0, 1'b0, 7'h7F, 12'h000, 1'b0, 1'b1);
    issue(1'b0, 4'h0, 1'b0, 13'd0);
    hdr(7'h7F, 1'b0, 1'b0, 1'b0, 12'h000);
    check("bytes", 36'(bytes), 36'h1000);
    done(13'h1000, 1'b1);
    $display("test dword and full count done");

    fwd(1'b1, 8'h20, 1'b1, 1'b1, 1'b0);
    fwd(1'b1, 8'h0F, 1'b1, 1'b1, 1'b0);
    fwd(1'b1, 8'h10, 1'b1, 1'b0, 1'b0);
    fwd(1'b1, 8'h20, 1'b0, 1'b0, 1'b0);
    fwd(1'b0, 8'h1F, 1'b0, 1'b0, 1'b1);
    fwd(1'b0, 8'h10, 1'b1, 1'b0, 1'b0);
    fwd(1'b0, 8'h20, 1'b0, 1'b0, 1'b0);
    fwd_in_valid = 1'b0;
    $display("test forwarding done");
    final_report;
  end

  initial begin
    #200000;
    miscompares++;
    $display("watchdog expired");
    final_report;
  end
endmodule
